// [sim/group_read_response_framer_test.sv]
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e); \
    end \
  end
// ------------------------------------------------
// bench top: host and group on one link, a lone group on a second
// ------------------------------------------------
module group_read_response_framer_test;
  localparam int MB = grp_pkg::MEMBERS;
  localparam int MW = grp_pkg::MAX_WORDS;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic mode2 = 1'b0, wr_valid = 1'b0, err1, err2, busy2;
  logic [7:0] wr_member = '0;
  logic [4:0] wr_addr = '0;
  logic [15:0] wr_data = '0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [15:0] mem [MB][MW];
  logic [7:0] qq[$], rq[$], rq2[$], exp_q[$], exp_r[$];
  int num_errors = 0, n_compared = 0, cycles = 0;
  grp_link_if link();
  grp_link_if link2();

  grp_host_master grp_host_master_i (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .link(link), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(), .o_rvalid(rvalid), .i_rready(rready));
  grp_node_device grp_node_device_i (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .link(link), .i_grouped_node_mode(1'b1),
    .i_wr_valid(wr_valid), .i_wr_member(wr_member), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .o_busy(), .o_query_err(err1));
  // second group, queried straight from the bench to break the rules
  grp_node_device grp_node_device_i2 (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .link(link2), .i_grouped_node_mode(mode2),
    .i_wr_valid(wr_valid), .i_wr_member(wr_member), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .o_busy(busy2), .o_query_err(err2));
  grp_link_checker #(.MB(MB), .MW(MW), .GA(grp_pkg::GROUP_ADDR_DFLT))
    grp_link_checker_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .q_data(link.q_data), .q_valid(link.q_valid), .q_ready(link.q_ready),
    .r_data(link.r_data), .r_valid(link.r_valid), .r_ready(link.r_ready));

  // clock, hang limit and stalls of the second receiver
  always #20 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cycles++;
    link2.r_ready <= ($urandom % 3) != 0;
    if (cycles == 40000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // negedge sampling sees what the next rising edge takes
  always @(negedge i_ref_clk) begin
    if (link.q_valid && link.q_ready) qq.push_back(link.q_data);
    if (link.r_valid && link.r_ready) rq.push_back(link.r_data);
    if (link2.r_valid && link2.r_ready) rq2.push_back(link2.r_data);
  end

  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] crc16(input logic [15:0] c,
                                        input logic [7:0] b);
    c = c ^ {8'h00, b};
    repeat (8) c = c[0] ? (c >> 1) ^ grp_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction

  function automatic void add_crc(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = grp_pkg::CRC_INIT;
    foreach (q[i]) c = crc16(c, q[i]);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction

  // expected query and response of one grouped read
  task automatic build(input logic [7:0] a, input logic [7:0] f,
                       input int st, input int w, input int adj);
    logic [15:0] cnt;
    cnt = 16'((w + 1) * MB + adj);
    exp_q = {a, f, 8'h00, 8'(st), cnt[15:8], cnt[7:0]};
    add_crc(exp_q);
    exp_r = {8'h0f, 8'h03, 8'(cnt << 1)};
    for (int m = 0; m < MB; m++) begin
      for (int i = 0; i < w; i++) begin
        exp_r.push_back(mem[m][st + i][15:8]);
        exp_r.push_back(mem[m][st + i][7:0]);
      end
      add_crc(exp_r);
    end
    add_crc(exp_r);
  endtask

  task automatic cmp(ref logic [7:0] got[$], ref logic [7:0] exp[$]);
    `CHK(got.size(), exp.size());
    foreach (exp[i]) begin
      if (i < got.size()) `CHK(got[i], exp[i])
    end
  endtask

  // one axi4-lite write or read, each channel released when taken
  task automatic axi(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    logic aw_p, w_p, b_p, ar_p, r_p;
    aw_p = wr;
    w_p = wr;
    b_p = wr;
    ar_p = !wr;
    r_p = !wr;
    rd = '0;
    @(posedge i_ref_clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    forever begin
      awvalid <= aw_p;
      wvalid <= w_p;
      bready <= b_p;
      arvalid <= ar_p;
      rready <= r_p;
      if (!(aw_p | w_p | b_p | ar_p | r_p)) break;
      @(negedge i_ref_clk);
      if (awready) aw_p = 1'b0;
      if (wready) w_p = 1'b0;
      if (bvalid) b_p = 1'b0;
      if (arready) ar_p = 1'b0;
      if (r_p && rvalid) rd = rdata;
      if (rvalid) r_p = 1'b0;
      @(posedge i_ref_clk);
    end
  endtask

  task automatic send2();
    foreach (exp_q[i]) begin
      @(posedge i_ref_clk);
      link2.q_data <= exp_q[i];
      link2.q_valid <= 1'b1;
      do @(negedge i_ref_clk); while (link2.q_ready !== 1'b1);
    end
    @(posedge i_ref_clk);
    link2.q_valid <= 1'b0;
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    logic [31:0] v;
    int st, w;
    int ws[9] = '{6, 24, 1, -1, -1, -1, -1, 24, 0};
    int sts[9] = '{0, 0, 23, 0, 0, 0, 0, 1, 0};
    logic [7:0] ad[6] = '{8'h0f, 8'h01, 8'h0f, 8'h0f, 8'h0f, 8'h0f};
    logic [7:0] fc[6] = '{8'h03, 8'h03, 8'h17, 8'h03, 8'h03, 8'h03};
    link2.q_data = '0;
    link2.q_valid = 1'b0;
    v = $urandom(32'hdb37);
    repeat (12) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    // fill words; the extra member index must be ignored
    for (int m = 0; m <= MB; m++) begin
      for (int a = 0; a < MW; a++) begin
        v = $urandom;
        @(posedge i_ref_clk);
        wr_valid <= 1'b1;
        wr_member <= 8'(m);
        wr_addr <= 5'(a);
        wr_data <= v[15:0];
        if (m < MB) mem[m][a] = v[15:0];
      end
    end
    @(posedge i_ref_clk);
    wr_valid <= 1'b0;
    axi(1'b0, grp_pkg::STAT_OFS, '0, v);
    `CHK(v[3:0], 4'h0);
    axi(1'b0, 12'h00c, '0, v);
    `CHK(v, 32'h0);
    // corners, random spans, then a span past the limit and an empty span
    for (int k = 0; k < 9; k++) begin
      w = ws[k];
      st = sts[k];
      if (w < 0) begin
        w = 1 + int'($urandom % 24);
        st = int'($urandom % (25 - w));
      end
      qq.delete();
      rq.delete();
      axi(1'b1, grp_pkg::CFG_OFS, (32'(w) << 8) | 32'(st), v);
      axi(1'b1, grp_pkg::CTRL_OFS, 32'h1, v);
      do axi(1'b0, grp_pkg::STAT_OFS, '0, v); while (v[0] !== 1'b0);
      if (w == 0 || st + w > 24) begin
        `CHK(v[3], 1'b1);
        `CHK(qq.size(), 0);
      end else begin
        build(8'h0f, 8'h03, st, w, 0);
        `CHK(v[3:1], 3'b001);
        cmp(qq, exp_q);
        cmp(rq, exp_r);
        `CHK(err1, 1'b0);
        for (int i = 0; i < MB * w; i++) begin
          axi(1'b0, grp_pkg::DATA_OFS
              + 12'(4 * ((i / w) * 24 + i % w)), '0, v);
          `CHK(v[15:0], mem[i / w][st + i % w]);
        end
      end
    end
    // mode off, foreign address, bad function, count, check; then good
    for (int j = 0; j < 6; j++) begin
      @(posedge i_ref_clk);
      mode2 <= j != 0;
      build(ad[j], fc[j], 2, 3, j == 3);
      if (j == 4) exp_q[6] = exp_q[6] ^ 8'h01;
      rq2.delete();
      send2();
      do @(negedge i_ref_clk); while (busy2 !== 1'b0 || link2.r_valid !== 1'b0);
      `CHK(err2, 1'(j inside {2, 3, 4}));
      `CHK(rq2.size(), j == 5 ? exp_r.size() : 0);
      if (j == 5) cmp(rq2, exp_r);
    end
    report_and_stop();
  end
endmodule // group_read_response_framer_test

// [sim/grp_link_checker.sv]
`timescale 1ns/100ps
// ------------------------------------------------
// link checker: watches the host to group byte streams
// ------------------------------------------------
module grp_link_checker #(
  parameter int MB = 2,
  parameter int MW = 24,
  parameter logic [7:0] GA = 8'h0f
) (
  input wire logic i_ref_clk, // clock
  input wire logic i_sys_rst, // sync reset, high
  input wire logic [7:0] q_data, // query byte
  input wire logic q_valid, // query offered
  input wire logic q_ready, // query accepted
  input wire logic [7:0] r_data, // response byte
  input wire logic r_valid, // response offered
  input wire logic r_ready // response accepted
);
  logic [2:0] qn_q;
  logic [1:0] rn_q;
  logic [15:0] cnt_q;
  wire qt = q_valid & q_ready;
  wire rt = r_valid & r_ready;
  wire [15:0] cnt_now = {cnt_q[7:0], q_data};

  // byte positions; response count restarts with each query
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      qn_q <= '0;
      rn_q <= '0;
      cnt_q <= '0;
    end else begin
      if (qt) qn_q <= qn_q + 3'h1;
      if (qt) rn_q <= 2'h0;
      else if (rt && rn_q != 2'h3) rn_q <= rn_q + 2'h1;
      if (qt && qn_q[2:1] == 2'b10) cnt_q <= cnt_now;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  chk_query_held: assert property (
    q_valid && !q_ready |=> q_valid && $stable(q_data))
    else $error("query byte changed before taken");
  chk_resp_held: assert property (
    r_valid && !r_ready |=> r_valid && $stable(r_data))
    else $error("response byte changed before taken");
  chk_group_addr: assert property (
    qt && qn_q == 3'h0 |-> q_data == GA)
    else $error("query not sent to group address");
  chk_func_code: assert property (
    qt && qn_q == 3'h1 |-> q_data == grp_pkg::FUNC_READ)
    else $error("query function code wrong");
  chk_count_form: assert property (
    qt && qn_q == 3'h5 |-> cnt_now % MB == 0 && cnt_now >= 16'(2 * MB)
      && cnt_now <= 16'((MW + 1) * MB))
    else $error("register count off the grouped formula");
  chk_resp_addr: assert property (
    rt && rn_q == 2'h0 |-> r_data == GA)
    else $error("response address not echoed");
  chk_resp_func: assert property (
    rt && rn_q == 2'h1 |-> r_data == grp_pkg::FUNC_READ)
    else $error("response function not echoed");
  chk_byte_count: assert property (
    rt && rn_q == 2'h2 |-> r_data == {cnt_q[6:0], 1'b0})
    else $error("byte count not twice register count");
  chk_answer_time: assert property (
    qt && qn_q == 3'h7 |=> !q_ready ##2 r_valid)
    else $error("response not started after query check");
endmodule // grp_link_checker

// [src/grp_host_master.sv]
`timescale 1ns/100ps
module grp_host_master #(
  parameter int MB = grp_pkg::MEMBERS,
  parameter int MW = grp_pkg::MAX_WORDS,
  parameter logic [7:0] GA = grp_pkg::GROUP_ADDR_DFLT
) (
  input wire logic i_ref_clk, // 25 mhz clock
  input wire logic i_sys_rst, // sync reset, high
  grp_link_if.host link, // bus side byte streams
  input wire logic [11:0] i_awaddr, // axi write address
  input wire logic i_awvalid, // axi
  output logic o_awready, // axi
  input wire logic [31:0] i_wdata, // axi write data
  input wire logic [3:0] i_wstrb, // axi byte enables
  input wire logic i_wvalid, // axi
  output logic o_wready, // axi
  output logic [1:0] o_bresp, // axi, always okay
  output logic o_bvalid, // axi
  input wire logic i_bready, // axi
  input wire logic [11:0] i_araddr, // axi read address
  input wire logic i_arvalid, // axi
  output logic o_arready, // axi
  output logic [31:0] o_rdata, // axi read data
  output logic [1:0] o_rresp, // axi, always okay
  output logic o_rvalid, // axi
  input wire logic i_rready // axi
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    grp_pkg::phase_t st;
    logic aw_ok;
    logic [11:0] awa;
    logic w_ok;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic rv;
    logic [31:0] rd;
    logic [4:0] start;
    logic [4:0] words;
    logic done;
    logic crc_err;
    logic frm_err;
    logic [2:0] qi;
    logic [15:0] crc;
    logic [15:0] chk;
    logic [1:0] hi;
    logic [7:0] mi;
    logic [4:0] wi;
    logic sel;
    logic [7:0] ub;
    logic [MB*MW-1:0][15:0] mem;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [15:0] cnt;
  logic [7:0] qb;
  logic [7:0] rb;
  logic rx;
  logic [31:0] rdv;
  int ri;

  assign cnt = 16'((int'(s_q.words) + 1) * MB);
  assign link.q_valid = (s_q.st == grp_pkg::ST_QUERY);
  assign link.q_data = qb;
  assign link.r_ready = (s_q.st >= grp_pkg::ST_HEAD);
  assign o_awready = !s_q.aw_ok && !s_q.bv;
  assign o_wready = !s_q.w_ok && !s_q.bv;
  assign o_bvalid = s_q.bv;
  assign o_bresp = grp_pkg::AXI_OKAY;
  assign o_arready = !s_q.rv;
  assign o_rvalid = s_q.rv;
  assign o_rdata = s_q.rd;
  assign o_rresp = grp_pkg::AXI_OKAY;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    rb = link.r_data;
    rx = link.r_valid && link.r_ready;
    ri = int'(s_q.mi) * MW + int'(s_q.wi);
    // whole range in one query, so both halves come together
    unique case (s_q.qi)
      3'd0: qb = GA;
      3'd1: qb = grp_pkg::FUNC_READ;
      3'd2: qb = 8'h00;
      3'd3: qb = {3'b000, s_q.start};
      3'd4: qb = cnt[15:8];
      3'd5: qb = cnt[7:0];
      3'd6: qb = s_q.crc[7:0];
      3'd7: qb = s_q.chk[15:8];
    endcase

    // register reads, unmapped offsets give zero
    rdv = 32'h0000_0000;
    if (i_araddr == grp_pkg::CFG_OFS) begin
      rdv[4:0] = s_q.start;
      rdv[grp_pkg::CFG_WORDS_LSB +: 5] = s_q.words;
    end else if (i_araddr == grp_pkg::STAT_OFS) begin
      rdv[grp_pkg::STAT_BUSY] = (s_q.st != grp_pkg::ST_IDLE);
      rdv[grp_pkg::STAT_DONE] = s_q.done;
      rdv[grp_pkg::STAT_CRC_ERR] = s_q.crc_err;
      rdv[grp_pkg::STAT_FRAME_ERR] = s_q.frm_err;
    end else if (i_araddr >= grp_pkg::DATA_OFS &&
                 int'(i_araddr - grp_pkg::DATA_OFS) < 4 * MB * MW) begin
      rdv[15:0] = s_q.mem[int'(i_araddr - grp_pkg::DATA_OFS) / 4];
    end
    if (i_arvalid && !s_q.rv) begin
      s_d.rv = 1'b1;
      s_d.rd = rdv;
    end else if (s_q.rv && i_rready) begin
      s_d.rv = 1'b0;
    end

    // write address and data in either order
    if (i_awvalid && o_awready) begin
      s_d.aw_ok = 1'b1;
      s_d.awa = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      s_d.w_ok = 1'b1;
      s_d.wd = i_wdata;
      s_d.ws = i_wstrb;
    end
    if (s_q.bv && i_bready) begin
      s_d.bv = 1'b0;
    end
    if (s_q.aw_ok && s_q.w_ok) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bv = 1'b1;
      if (s_q.awa == grp_pkg::CFG_OFS && s_q.st == grp_pkg::ST_IDLE) begin
        if (s_q.ws[0]) s_d.start = s_q.wd[4:0];
        if (s_q.ws[1]) s_d.words = s_q.wd[grp_pkg::CFG_WORDS_LSB +: 5];
      end
      if (s_q.awa == grp_pkg::CTRL_OFS && s_q.ws[0] && s_q.wd[0] &&
          s_q.st == grp_pkg::ST_IDLE) begin
        s_d.done = 1'b0;
        s_d.crc_err = 1'b0;
        s_d.qi = 3'd0;
        s_d.crc = grp_pkg::CRC_INIT;
        // refuse an empty or oversized range without sending
        if (s_q.words == 5'd0 || int'(s_q.words) > MW ||
            int'(s_q.start) + int'(s_q.words) > MW) begin
          s_d.frm_err = 1'b1;
        end else begin
          s_d.frm_err = 1'b0;
          s_d.st = grp_pkg::ST_QUERY;
        end
      end
    end

    // query out, then response in
    unique case (s_q.st)
      grp_pkg::ST_IDLE, grp_pkg::ST_CHECK: begin
        s_d.hi = 2'd0;
      end
      grp_pkg::ST_QUERY: begin
        if (link.q_ready) begin
          s_d.crc = grp_pkg::crc_byte(s_q.crc, qb);
          s_d.qi = s_q.qi + 3'd1;
          if (s_q.qi == 3'd6) s_d.chk = s_q.crc;
          if (s_q.qi == 3'd7) begin
            s_d.st = grp_pkg::ST_HEAD;
            s_d.crc = grp_pkg::CRC_INIT;
            s_d.hi = 2'd0;
            s_d.mi = 8'h00;
            s_d.wi = 5'd0;
            s_d.sel = 1'b0;
          end
        end
      end
      grp_pkg::ST_HEAD: begin
        if (rx) begin
          s_d.crc = grp_pkg::crc_byte(s_q.crc, rb);
          s_d.hi = s_q.hi + 2'd1;
          if ((s_q.hi == 2'd0 && rb != GA) ||
              (s_q.hi == 2'd1 && rb != grp_pkg::FUNC_READ) ||
              (s_q.hi == 2'd2 && rb != {cnt[6:0], 1'b0})) begin
            s_d.frm_err = 1'b1;
          end
          if (s_q.hi == grp_pkg::HEAD_LAST) s_d.st = grp_pkg::ST_DATA;
        end
      end
      grp_pkg::ST_DATA: begin
        if (rx) begin
          s_d.crc = grp_pkg::crc_byte(s_q.crc, rb);
          s_d.sel = !s_q.sel;
          if (!s_q.sel) begin
            s_d.ub = rb;
          end else begin
            s_d.mem[ri] = {s_q.ub, rb};
            if (s_q.wi == s_q.words - 5'd1) begin
              s_d.st = grp_pkg::ST_LINK;
            end else begin
              s_d.wi = s_q.wi + 5'd1;
            end
          end
        end
      end
      grp_pkg::ST_LINK, grp_pkg::ST_END: begin
        if (rx) begin
          s_d.crc = grp_pkg::crc_byte(s_q.crc, rb);
          s_d.sel = !s_q.sel;
          if (!s_q.sel) begin
            s_d.chk = s_q.crc;
            if (rb != s_q.crc[7:0]) s_d.crc_err = 1'b1;
          end else begin
            if (rb != s_q.chk[15:8]) s_d.crc_err = 1'b1;
            s_d.wi = 5'd0;
            if (s_q.st == grp_pkg::ST_END) begin
              s_d.done = 1'b1;
              s_d.st = grp_pkg::ST_IDLE;
            end else if (int'(s_q.mi) == MB - 1) begin
              s_d.st = grp_pkg::ST_END;
            end else begin
              s_d.mi = s_q.mi + 8'h01;
              s_d.st = grp_pkg::ST_DATA;
            end
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.crc <= grp_pkg::CRC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // grp_host_master

// [src/grp_link_if.sv]
`timescale 1ns/100ps
// byte streams: query from host, response from the group
interface grp_link_if;
  logic [7:0] q_data;
  logic q_valid;
  logic q_ready;
  logic [7:0] r_data;
  logic r_valid;
  logic r_ready;

  modport host (output q_data, output q_valid, input q_ready,
                input r_data, input r_valid, output r_ready);
  modport device (input q_data, input q_valid, output q_ready,
                  output r_data, output r_valid, input r_ready);
endinterface

// [src/grp_node_device.sv]
`timescale 1ns/100ps
module grp_node_device #(
  parameter int MB = grp_pkg::MEMBERS,
  parameter int MW = grp_pkg::MAX_WORDS,
  parameter logic [7:0] GA = grp_pkg::GROUP_ADDR_DFLT
) (
  input wire logic i_ref_clk, // 25 mhz clock
  input wire logic i_sys_rst, // sync reset, high
  grp_link_if.device link, // bus side byte streams
  input wire logic i_grouped_node_mode, // answer group queries
  input wire logic i_wr_valid, // local word update
  input wire logic [7:0] i_wr_member, // member, 0 = index 1
  input wire logic [4:0] i_wr_addr, // grouped word address
  input wire logic [15:0] i_wr_data, // word value
  output logic o_busy, // query check or response framing in progress
  output logic o_query_err // last addressed query bad
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    grp_pkg::phase_t st;
    logic [7:0][7:0] q; // query bytes
    logic [3:0] qn;
    logic [15:0] crc; // running check
    logic [15:0] chk; // check latched for upper byte
    logic [MB*MW-1:0][15:0] mem;
    logic [7:0] mi; // member being framed
    logic [4:0] wi;
    logic [4:0] start;
    logic [5:0] nw;
    logic [15:0] cnt;
    logic [1:0] hi;
    logic sel;
    logic [1:0][7:0] fb; // two-entry output buffer
    logic [1:0] fn;
    logic err;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [7:0] tx;
  logic emit;
  logic push;
  logic pop;
  logic [15:0] word;
  int words_i;
  int widx_i;
  logic cnt_ok;
  logic addressed;

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.q_ready = (s_q.st == grp_pkg::ST_QUERY);
  assign link.r_valid = (s_q.fn != 2'd0);
  assign link.r_data = s_q.fb[0];
  assign o_busy = (s_q.st != grp_pkg::ST_QUERY);
  assign o_query_err = s_q.err;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    tx = 8'h00;
    emit = 1'b0;
    words_i = int'(s_q.cnt) / MB - 1;
    widx_i = int'(s_q.mi) * MW + int'(s_q.start) + int'(s_q.wi);
    word = s_q.mem[widx_i];
    // count must be exact multiple, 1..24 words inside the area
    cnt_ok = (int'(s_q.cnt) == (words_i + 1) * MB) &&
             (words_i >= 1) && (words_i <= MW) &&
             (int'(s_q.q[3]) + words_i <= MW) &&
             (s_q.q[2] == 8'h00);
    addressed = (s_q.q[0] == GA) && i_grouped_node_mode;

    // local updates go straight in, so a later read sees them
    if (i_wr_valid && int'(i_wr_member) < MB && int'(i_wr_addr) < MW)
    begin
      s_d.mem[int'(i_wr_member) * MW + int'(i_wr_addr)] = i_wr_data;
    end

    // byte to send in the present phase
    unique case (s_q.st)
      grp_pkg::ST_HEAD: begin
        emit = 1'b1;
        if (s_q.hi == 2'd0) begin
          tx = GA;
        end else if (s_q.hi == 2'd1) begin
          tx = grp_pkg::FUNC_READ;
        end else begin
          tx = {s_q.cnt[6:0], 1'b0};
        end
      end
      grp_pkg::ST_DATA: begin
        emit = 1'b1;
        tx = s_q.sel ? word[7:0] : word[15:8];
      end
      grp_pkg::ST_LINK, grp_pkg::ST_END: begin
        emit = 1'b1;
        tx = s_q.sel ? s_q.chk[15:8] : s_q.crc[7:0];
      end
      grp_pkg::ST_IDLE, grp_pkg::ST_QUERY, grp_pkg::ST_CHECK: begin
        emit = 1'b0;
      end
    endcase

    // buffer: pop toward the host, push from the framer
    pop = link.r_ready && (s_q.fn != 2'd0);
    push = emit && (s_q.fn != 2'd2); // receiver stall halts framer
    if (pop) begin
      s_d.fb[0] = s_q.fb[1];
      s_d.fn = s_q.fn - 2'd1;
    end
    if (push) begin
      s_d.fb[s_d.fn[0]] = tx;
      s_d.fn = s_d.fn + 2'd1;
      s_d.crc = grp_pkg::crc_byte(s_q.crc, tx);
    end

    // frame sequencing
    unique case (s_q.st)
      grp_pkg::ST_IDLE: begin
        s_d.st = grp_pkg::ST_QUERY;
      end
      grp_pkg::ST_QUERY: begin
        // no gap timing: byte alignment is assumed from reset on
        if (link.q_valid) begin
          s_d.q[s_q.qn[2:0]] = link.q_data;
          // count bytes kept whole, so check and header see them
          s_d.cnt = {s_d.q[4], s_d.q[5]};
          s_d.crc = grp_pkg::crc_byte(s_q.crc, link.q_data);
          s_d.qn = s_q.qn + 4'd1;
          if (s_q.qn == grp_pkg::QUERY_LAST) begin
            s_d.st = grp_pkg::ST_CHECK;
          end
        end
      end
      grp_pkg::ST_CHECK: begin
        s_d.qn = 4'd0;
        s_d.hi = 2'd0;
        s_d.mi = 8'h00;
        s_d.wi = 5'd0;
        s_d.sel = 1'b0;
        s_d.start = s_q.q[3][4:0];
        s_d.nw = 6'(words_i);
        s_d.crc = grp_pkg::CRC_INIT;
        s_d.st = grp_pkg::ST_QUERY;
        if (addressed) begin
          // a correct frame checks to zero over its own crc
          if (s_q.crc == 16'h0000 && s_q.q[1] == grp_pkg::FUNC_READ &&
              cnt_ok) begin
            s_d.err = 1'b0;
            s_d.st = grp_pkg::ST_HEAD;
          end else begin
            s_d.err = 1'b1;
          end
        end
      end
      grp_pkg::ST_HEAD: begin
        if (push) begin
          s_d.hi = s_q.hi + 2'd1;
          if (s_q.hi == grp_pkg::HEAD_LAST) begin
            s_d.st = grp_pkg::ST_DATA;
          end
        end
      end
      grp_pkg::ST_DATA: begin
        if (push) begin
          s_d.sel = !s_q.sel;
          if (s_q.sel) begin
            if ({1'b0, s_q.wi} == s_q.nw - 6'd1) begin
              s_d.st = grp_pkg::ST_LINK;
            end else begin
              s_d.wi = s_q.wi + 5'd1;
            end
          end
        end
      end
      grp_pkg::ST_LINK: begin
        if (push) begin
          s_d.sel = !s_q.sel;
          if (!s_q.sel) begin
            s_d.chk = s_q.crc;
          end else begin
            s_d.wi = 5'd0;
            // next member starts only after this check is out
            if (int'(s_q.mi) == MB - 1) begin
              s_d.st = grp_pkg::ST_END;
            end else begin
              s_d.mi = s_q.mi + 8'h01;
              s_d.st = grp_pkg::ST_DATA;
            end
          end
        end
      end
      grp_pkg::ST_END: begin
        if (push) begin
          s_d.sel = !s_q.sel;
          if (!s_q.sel) begin
            s_d.chk = s_q.crc;
          end else begin
            s_d.crc = grp_pkg::CRC_INIT;
            s_d.st = grp_pkg::ST_QUERY;
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.st <= grp_pkg::ST_QUERY;
      s_q.crc <= grp_pkg::CRC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // grp_node_device

// [src/grp_pkg.sv]
package grp_pkg;

  // ---------------------------------------------------------------
  // frame codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FUNC_READ = 8'h03; // read holding registers
  localparam logic [7:0] GROUP_ADDR_DFLT = 8'h0f; // group address 15
  localparam int MAX_WORDS = 24; // words per node at most
  localparam int MEMBERS = 2; // member nodes in the group
  localparam logic [3:0] QUERY_LAST = 4'h7; // index of last query byte
  localparam logic [1:0] HEAD_LAST = 2'h2; // index of byte count
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // ---------------------------------------------------------------
  // grouped read area, word addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] SLOT0_HIGH = 16'h0000;
  localparam logic [15:0] SLOT0_LOW = 16'h0001;
  localparam logic [15:0] SLOT1_HIGH = 16'h0002;
  localparam logic [15:0] SLOT1_LOW = 16'h0003;
  localparam logic [15:0] SLOT2_HIGH = 16'h0004;
  localparam logic [15:0] SLOT2_LOW = 16'h0005;

  // ---------------------------------------------------------------
  // host controller registers, byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000; // bit0 start
  localparam logic [11:0] CFG_OFS = 12'h004; // [4:0] start, [12:8] words
  localparam logic [11:0] STAT_OFS = 12'h008; // busy,done,crc,frame
  localparam logic [11:0] DATA_OFS = 12'h100; // received words
  localparam int CFG_WORDS_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_CRC_ERR = 2;
  localparam int STAT_FRAME_ERR = 3;
  localparam logic [1:0] AXI_OKAY = 2'h0;

  // frame phases shared by both ends
  typedef enum logic [2:0] {
    ST_IDLE, ST_QUERY, ST_CHECK, ST_HEAD, ST_DATA, ST_LINK, ST_END
  } phase_t;

  // one byte step of the reflected check, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage
